/* File: src/spb_consts.svh */
`ifndef SPB_CONSTS_SVH
`define SPB_CONSTS_SVH

// system clock
`define SPB_CLK_HZ        50000000
`define SPB_CLK_MHZ       50

// line rate and bit period, rounded to the nearest cycle
`define SPB_BAUD          19200
`define SPB_BIT_CYC       ((`SPB_CLK_HZ + `SPB_BAUD / 2) / `SPB_BAUD)

// acknowledge deadline after release (longest: rounds down)
`define SPB_ACK_MAX_US    16000
`define SPB_ACK_MAX_CYC   (`SPB_ACK_MAX_US * `SPB_CLK_MHZ)

// hold-off before the data-frame acknowledge (least: rounds up)
`define SPB_DACK_MIN_US   850
`define SPB_DACK_MIN_CYC  (`SPB_DACK_MIN_US * `SPB_CLK_MHZ)

// dead time before the result byte (least: rounds up)
`define SPB_RES_GAP_US    250
`define SPB_RES_GAP_CYC   (`SPB_RES_GAP_US * `SPB_CLK_MHZ)

// command frame layout
`define SPB_CMD_BYTES     5
`define SPB_IDX_ID        0
`define SPB_IDX_CODE      1
`define SPB_IDX_AUX1      2
`define SPB_IDX_AUX2      3
`define SPB_IDX_SUM       4

// reply codes
`define SPB_CODE_ACK      8'h41
`define SPB_CODE_NAK      8'h4e
`define SPB_CODE_DONE     8'h43
`define SPB_CODE_ERR      8'h45

// bus address of this peripheral; value is arbitrary
`define SPB_DEV_ID        8'h5a

// counter widths
`define SPB_TMR_W         24
`define SPB_BIT_W         16

`endif

/* File: src/spb_pkg.sv */
`default_nettype none

package spb_pkg;

	// data frame direction of a command
	typedef enum logic [1:0] {SPB_DIR_NONE, SPB_DIR_WRITE, SPB_DIR_READ} spb_dir_e;

	// serial receiver
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spb_rx_e;

	// command sequencer
	typedef enum logic [3:0] {
		ST_COLLECT, ST_CHECK, ST_DECIDE, ST_CACK, ST_NAK, ST_WDATA,
		ST_WHOLD, ST_DACK, ST_EXEC, ST_RESULT, ST_RDATA, ST_RSUM
	} spb_state_e;

	// carry wrap-around add; 0xff plus a carry cannot occur
	function automatic logic [7:0] spb_csum_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction : spb_csum_add

endpackage : spb_pkg

`default_nettype wire

/* File: src/spb_fifo.sv */
`default_nettype none

module spb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	import spb_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [PW:0]      cnt_reg, cnt_next;
	logic             push, pop;

	// honest flags straight from the occupancy count
	assign in_ready_o  = (cnt_reg != FULL);
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o  = mem[rd_reg];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_ready_i && out_valid_o;

	// pointer and count update, wrapping at any depth
	always_comb
	begin
		wr_next  = wr_reg;
		rd_next  = rd_reg;
		cnt_next = cnt_reg;
		if (push)
			wr_next = (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
		if (pop)
			rd_next = (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
		if (push && !pop)
			cnt_next = cnt_reg + 1'b1;
		else if (pop && !push)
			cnt_next = cnt_reg - 1'b1;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// storage needs no reset; unread words are never shown as valid
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_reg] <= in_data_i;
	end

endmodule : spb_fifo

`default_nettype wire

/* File: src/spb_cmd_seq.sv */
// Contract
// - frames run at 19200 baud, no parity.
// - byte is start bit, eight data bits lsb first, one stop bit.
// - command line is active low, held low during the command frame.
// - command frame is id, command, aux1, aux2, checksum.
// - checksum is 8-bit sum with carries folded back in.
// - host holds command low after last byte; device assumes no minimum.
// - wrong id, framing or checksum error: discard silently, no reply.
// - accepted frame gets 0x41 when valid, 0x4e otherwise.
// - command acknowledge waits until command line seen high.
// - command acknowledge starts within 16 ms of release.
// - unsupported code or bad parameters get negative acknowledge.
// - after negative acknowledge, end command, send nothing more.
// - every data frame ends in one checksum byte over its data.
// - data acknowledge comes 850 us to 16 ms after last data byte.
// - bad host data frame: negative acknowledge, no result byte.
// - at least 250 us idle between last acknowledge and result byte.
// - result byte is 0x43 on success, 0x45 on failure.
// - read commands send data frame after result byte, even on error.
// - data frame presence, direction, length fixed per command code.
// - optionally reject frames whose command line rose too early.
// - whole host data frame is taken before execution starts.
`include "spb_consts.svh"
`default_nettype none

module spb_cmd_seq #(
	parameter int         BIT_CYC      = `SPB_BIT_CYC,
	parameter int         ACK_MAX_CYC  = `SPB_ACK_MAX_CYC,
	parameter int         DECIDE_CYC   = `SPB_ACK_MAX_CYC / 2,
	parameter int         DACK_MIN_CYC = `SPB_DACK_MIN_CYC,
	parameter int         RES_GAP_CYC  = `SPB_RES_GAP_CYC,
	parameter logic [7:0] DEVICE_ID    = `SPB_DEV_ID,
	parameter bit         REJECT_EARLY = 1'b0,
	parameter int         LEN_W        = 9,
	parameter int         FIFO_DEPTH   = 4
) (
	input  wire logic                 clk_i,
	input  wire logic                 reset_n_i,
	input  wire logic                 host_line_i,
	input  wire logic                 cmd_n_i,
	output var logic                  dev_line_o,
	output var logic                  cmd_req_o,
	output var logic [7:0]            cmd_code_o,
	output var logic [7:0]            cmd_aux1_o,
	output var logic [7:0]            cmd_aux2_o,
	input  wire logic                 cmd_resp_i,
	input  wire logic                 cmd_ok_i,
	input  wire spb_pkg::spb_dir_e    cmd_dir_i,
	input  wire logic [LEN_W-1:0]     cmd_len_i,
	output var logic [7:0]            wr_byte_o,
	output var logic                  wr_strobe_o,
	output var logic                  cmd_abort_o,
	output var logic                  exec_start_o,
	input  wire logic                 exec_done_i,
	input  wire logic                 exec_ok_i,
	input  wire logic [7:0]           rd_data_i,
	input  wire logic                 rd_valid_i,
	output logic                      rd_ready_o
);
	import spb_pkg::*;

	localparam logic [`SPB_BIT_W-1:0] BIT_LAST = `SPB_BIT_W'(BIT_CYC - 1);
	localparam logic [`SPB_BIT_W-1:0] BIT_HALF = `SPB_BIT_W'(BIT_CYC / 2 - 1);
	// rx finishes mid stop bit, so add half a bit to reach the byte's end
	localparam logic [`SPB_TMR_W-1:0] T_DECIDE = `SPB_TMR_W'(DECIDE_CYC);
	localparam logic [`SPB_TMR_W-1:0] T_DACK   = `SPB_TMR_W'(DACK_MIN_CYC + BIT_CYC / 2);
	localparam logic [`SPB_TMR_W-1:0] T_GAP    = `SPB_TMR_W'(RES_GAP_CYC);

	// pin synchronisers; only stage two and later are read
	logic host_s1, host_s2, cmd_s1, cmd_s2, cmd_d;
	logic cmd_fall, cmd_rise;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			{host_s1, host_s2, cmd_s1, cmd_s2, cmd_d} <= 5'h1f;
		else
			{host_s1, host_s2, cmd_s1, cmd_s2, cmd_d} <= {host_line_i, host_s1, cmd_n_i, cmd_s1, cmd_s2};
	end

	assign cmd_fall = cmd_d && !cmd_s2;
	assign cmd_rise = !cmd_d && cmd_s2;

	// receiver: half-bit start qualify, mid-bit sampling
	spb_rx_e                rx_st, rx_st_next;
	logic [`SPB_BIT_W-1:0]  rx_cnt, rx_cnt_next;
	logic [2:0]             rx_bit, rx_bit_next;
	logic [7:0]             rx_sh, rx_sh_next, rx_byte, rx_byte_next;
	logic                   rx_done, rx_done_next, rx_ferr, rx_ferr_next;

	always_comb
	begin
		rx_st_next   = rx_st;
		rx_cnt_next  = (rx_cnt == '0) ? BIT_LAST : rx_cnt - 1'b1;
		rx_bit_next  = rx_bit;
		rx_sh_next   = rx_sh;
		rx_byte_next = rx_byte;
		rx_ferr_next = rx_ferr;
		rx_done_next = 1'b0;
		unique case (rx_st)
			RX_IDLE:
			begin
				rx_cnt_next = BIT_HALF;
				if (!host_s2)
					rx_st_next = RX_START;
			end
			RX_START:
				if (rx_cnt == '0)
				begin
					rx_bit_next = 3'h0;
					rx_st_next  = host_s2 ? RX_IDLE : RX_DATA;  // glitch is no start
				end
			RX_DATA:
				if (rx_cnt == '0)
				begin
					rx_sh_next  = {host_s2, rx_sh[7:1]};  // lsb first
					rx_bit_next = rx_bit + 1'b1;
					if (rx_bit == 3'h7)
						rx_st_next = RX_STOP;
				end
			RX_STOP:
				if (rx_cnt == '0)
				begin
					rx_byte_next = rx_sh;
					rx_ferr_next = !host_s2;  // missing stop bit
					rx_done_next = 1'b1;
					rx_st_next   = RX_IDLE;
				end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rx_st   <= RX_IDLE;
			rx_cnt  <= '0;
			rx_bit  <= 3'h0;
			rx_sh   <= 8'h00;
			rx_byte <= 8'h00;
			rx_ferr <= 1'b0;
			rx_done <= 1'b0;
		end
		else
		begin
			rx_st   <= rx_st_next;
			rx_cnt  <= rx_cnt_next;
			rx_bit  <= rx_bit_next;
			rx_sh   <= rx_sh_next;
			rx_byte <= rx_byte_next;
			rx_ferr <= rx_ferr_next;
			rx_done <= rx_done_next;
		end
	end

	// transmitter: ten-bit frame, line idles high out of tx_sh[0]
	logic                   tx_go, tx_busy, tx_busy_next, tx_done, tx_done_next;
	logic [7:0]             tx_byte;
	logic [9:0]             tx_sh, tx_sh_next;
	logic [3:0]             tx_left, tx_left_next;
	logic [`SPB_BIT_W-1:0]  tx_cnt, tx_cnt_next;

	always_comb
	begin
		tx_sh_next   = tx_sh;
		tx_left_next = tx_left;
		tx_busy_next = tx_busy;
		tx_cnt_next  = (tx_cnt == '0) ? BIT_LAST : tx_cnt - 1'b1;
		tx_done_next = 1'b0;
		if (tx_go)
		begin
			tx_sh_next   = {1'b1, tx_byte, 1'b0};  // stop, data, start
			tx_left_next = 4'ha;
			tx_cnt_next  = BIT_LAST;
			tx_busy_next = 1'b1;
		end
		else if (tx_busy && tx_cnt == '0)
		begin
			tx_sh_next   = {1'b1, tx_sh[9:1]};
			tx_left_next = tx_left - 1'b1;
			if (tx_left == 4'h1)
			begin
				tx_busy_next = 1'b0;
				tx_done_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tx_sh   <= 10'h3ff;
			tx_left <= 4'h0;
			tx_cnt  <= '0;
			tx_busy <= 1'b0;
			tx_done <= 1'b0;
		end
		else
		begin
			tx_sh   <= tx_sh_next;
			tx_left <= tx_left_next;
			tx_cnt  <= tx_cnt_next;
			tx_busy <= tx_busy_next;
			tx_done <= tx_done_next;
		end
	end

	assign dev_line_o = tx_sh[0];

	// read data waits in a small fifo; an empty fifo stalls the frame
	logic       fifo_valid, fifo_pop;
	logic [7:0] fifo_data;

	spb_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) spb_fifo_i (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.in_data_i   (rd_data_i),
		.in_valid_i  (rd_valid_i),
		.in_ready_o  (rd_ready_o),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop)
	);

	// command sequencer state
	spb_state_e             st, st_next;
	logic [LEN_W-1:0]       cnt, cnt_next, len, len_next;
	logic [7:0]             sum, sum_next, code_next, aux1_next, aux2_next, wbyte_next;
	logic [`SPB_TMR_W-1:0]  tmr, tmr_next;
	spb_dir_e               dir, dir_next;
	logic                   err, err_next, early, early_next, sent, sent_next;
	logic                   done, done_next, res_ok, res_ok_next, take_cmd, send_st;
	logic                   req_next, strobe_next, abort_next, exec_next;

	assign send_st  = st inside {ST_CACK, ST_NAK, ST_DACK, ST_RESULT, ST_RDATA, ST_RSUM};
	assign tx_go    = send_st && !tx_busy && !sent && (st != ST_RDATA || fifo_valid);
	assign fifo_pop = tx_go && st == ST_RDATA;
	// bytes that land after release still belong to the frame
	assign take_cmd = rx_done && ((st == ST_COLLECT && !cmd_s2) || st == ST_CHECK);

	// reply byte for the current state
	always_comb
	begin
		if (st == ST_NAK)
			tx_byte = `SPB_CODE_NAK;
		else if (st == ST_RESULT)
			tx_byte = res_ok ? `SPB_CODE_DONE : `SPB_CODE_ERR;
		else if (st == ST_RDATA)
			tx_byte = fifo_data;
		else if (st == ST_RSUM)
			tx_byte = sum;
		else
			tx_byte = `SPB_CODE_ACK;
	end

	always_comb
	begin
		st_next     = st;
		cnt_next    = cnt;
		len_next    = len;
		sum_next    = sum;
		err_next    = err;
		dir_next    = dir;
		early_next  = early;
		done_next   = done;
		res_ok_next = res_ok;
		code_next   = cmd_code_o;
		aux1_next   = cmd_aux1_o;
		aux2_next   = cmd_aux2_o;
		wbyte_next  = wr_byte_o;
		tmr_next    = (&tmr) ? tmr : tmr + 1'b1;  // saturating delay counter
		sent_next   = tx_done ? 1'b0 : (sent || tx_go);
		req_next    = 1'b0;
		strobe_next = 1'b0;
		abort_next  = 1'b0;
		exec_next   = 1'b0;
		// five-byte frame: id, code, aux1, aux2, checksum
		if (take_cmd)
		begin
			err_next = err || rx_ferr;
			if (cnt == LEN_W'(`SPB_IDX_ID))
				err_next = err || rx_ferr || rx_byte != DEVICE_ID;
			else if (cnt == LEN_W'(`SPB_IDX_CODE))
				code_next = rx_byte;
			else if (cnt == LEN_W'(`SPB_IDX_AUX1))
				aux1_next = rx_byte;
			else if (cnt == LEN_W'(`SPB_IDX_AUX2))
				aux2_next = rx_byte;
			else if (cnt == LEN_W'(`SPB_IDX_SUM))
				err_next = err || rx_ferr || rx_byte != sum;
			if (cnt < LEN_W'(`SPB_IDX_SUM))
				sum_next = spb_csum_add(sum, rx_byte);
			if (cnt <= LEN_W'(`SPB_CMD_BYTES))
				cnt_next = cnt + 1'b1;
		end
		unique case (st)
			ST_COLLECT:
				if (cmd_fall)
				begin
					cnt_next = '0;
					sum_next = 8'h00;
					err_next = 1'b0;
				end
				else if (cmd_rise)
				begin
					st_next    = ST_CHECK;  // replies only once the line is high
					tmr_next   = '0;
					early_next = (rx_st != RX_IDLE);  // released mid byte
				end
			ST_CHECK:
				if (rx_st == RX_IDLE && !rx_done)
				begin
					if (err || cnt != LEN_W'(`SPB_CMD_BYTES) || (REJECT_EARLY && early))
					begin
						st_next  = ST_COLLECT;  // silent drop
						cnt_next = '0;
					end
					else
					begin
						st_next  = ST_DECIDE;
						req_next = 1'b1;
					end
				end
			ST_DECIDE:
				if (cmd_resp_i)
				begin
					dir_next = cmd_dir_i;  // framing fixed by code
					len_next = cmd_len_i;
					st_next  = cmd_ok_i ? ST_CACK : ST_NAK;
				end
				else if (tmr >= T_DECIDE)
					st_next = ST_NAK;  // no verdict in time
			ST_CACK:
				if (tx_done)
				begin
					tmr_next = '0;
					if (dir == SPB_DIR_WRITE && len != '0)
					begin
						st_next  = ST_WDATA;
						cnt_next = '0;
						sum_next = 8'h00;
						err_next = 1'b0;
					end
					else
					begin
						st_next   = ST_EXEC;
						exec_next = 1'b1;
						done_next = 1'b0;
					end
				end
			ST_WDATA:
				if (rx_done)
				begin
					if (cnt < len)
					begin
						wbyte_next  = rx_byte;
						strobe_next = 1'b1;
						sum_next    = spb_csum_add(sum, rx_byte);
						err_next    = err || rx_ferr;
						cnt_next    = cnt + 1'b1;
					end
					else
					begin
						err_next = err || rx_ferr || rx_byte != sum;
						st_next  = ST_WHOLD;
						tmr_next = '0;
					end
				end
			ST_WHOLD:
				if (tmr >= T_DACK)
				begin
					st_next    = err ? ST_NAK : ST_DACK;
					abort_next = err;
				end
			ST_DACK:
				if (tx_done)
				begin
					st_next   = ST_EXEC;  // frame complete before start
					exec_next = 1'b1;
					done_next = 1'b0;
					tmr_next  = '0;
				end
			ST_EXEC:
			begin
				if (exec_done_i && !done)
				begin
					done_next   = 1'b1;
					res_ok_next = exec_ok_i;
				end
				if (done && tmr >= T_GAP)
					st_next = ST_RESULT;  // dead time after acknowledge
			end
			ST_RESULT:
				if (tx_done)
				begin
					cnt_next = '0;
					sum_next = 8'h00;
					err_next = 1'b0;  // next command may fall before this byte ends
					st_next  = (dir == SPB_DIR_READ && len != '0) ? ST_RDATA : ST_COLLECT;
				end
			ST_RDATA:
			begin
				if (tx_go)
				begin
					sum_next = spb_csum_add(sum, fifo_data);
					cnt_next = cnt + 1'b1;
				end
				if (tx_done && cnt == len)
					st_next = ST_RSUM;
			end
			ST_NAK, ST_RSUM:
				if (tx_done)
				begin
					st_next  = ST_COLLECT;  // nothing more follows
					cnt_next = '0;
					sum_next = 8'h00;  // a missed command fall must not inherit old state
					err_next = 1'b0;
				end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			st <= ST_COLLECT;
			{cnt, len} <= '0;
			{sum, cmd_code_o, cmd_aux1_o, cmd_aux2_o, wr_byte_o} <= '0;
			tmr <= '0;
			dir <= SPB_DIR_NONE;
			{err, early, sent, done, res_ok} <= 5'h00;
			{cmd_req_o, wr_strobe_o, cmd_abort_o, exec_start_o} <= 4'h0;
		end
		else
		begin
			st <= st_next;
			{cnt, len} <= {cnt_next, len_next};
			{sum, cmd_code_o, cmd_aux1_o, cmd_aux2_o, wr_byte_o} <=
				{sum_next, code_next, aux1_next, aux2_next, wbyte_next};
			tmr <= tmr_next;
			dir <= dir_next;
			{err, early, sent, done, res_ok} <= {err_next, early_next, sent_next, done_next, res_ok_next};
			{cmd_req_o, wr_strobe_o, cmd_abort_o, exec_start_o} <=
				{req_next, strobe_next, abort_next, exec_next};
		end
	end

	// checks on the sequencer
	a_ack_held_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		tx_go && (st == ST_CACK || (st == ST_NAK && dir != SPB_DIR_WRITE)) |-> cmd_s2)
		else $error("acknowledge started while command line low");
	a_ack_deadline: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		st == ST_DECIDE |-> tmr <= T_DECIDE)
		else $error("verdict wait overran its deadline");
	a_nak_code: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		tx_go && st == ST_NAK |=> tx_sh[8:1] == `SPB_CODE_NAK)
		else $error("negative acknowledge sent wrong code");
	a_nak_ends_cmd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		st == ST_NAK && tx_done |=> st == ST_COLLECT ##1 !exec_start_o)
		else $error("command went on after negative acknowledge");
	a_bad_frame_drop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		st == ST_CHECK && rx_st == RX_IDLE && !rx_done && err |=> st == ST_COLLECT && !cmd_req_o)
		else $error("bad command frame was not discarded");
	a_dack_window: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$rose(st == ST_DACK) |-> $past(tmr) >= T_DACK && $past(tmr) <= T_DACK)
		else $error("data acknowledge outside its window");
	a_result_gap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		tx_go && st == ST_RESULT |-> tmr >= T_GAP)
		else $error("result byte too soon after acknowledge");
	a_start_bit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		tx_go |=> !dev_line_o [*8])
		else $error("start bit missing or cut short");
	a_exec_after_frame: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		exec_start_o && dir == SPB_DIR_WRITE && len != '0 |-> $past(st) == ST_DACK)
		else $error("write executed before frame accepted");
	a_data_nak_abort: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		st == ST_WHOLD && tmr >= T_DACK && err |=> st == ST_NAK && cmd_abort_o)
		else $error("bad data frame not refused");

endmodule : spb_cmd_seq

`default_nettype wire

/* File: tb/spb_host_model.sv */
`default_nettype none

module spb_host_model #(
	parameter int BIT_CYC = 16
) (
	input  wire logic clk_i,
	input  wire logic dev_line_i,
	output logic      host_line_o,
	output logic      cmd_n_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// both lines idle high between frames
	initial
	begin
		host_line_o = 1'b1;
		cmd_n_o = 1'b1;
	end

	// carry folded back so the sum never leaves eight bits
	function automatic logic [7:0] fold(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction : fold

	// start bit, eight bits lsb first, stop bit
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk_i);
			#1;
			host_line_o = f[i];
			repeat (BIT_CYC - 1) @(posedge clk_i);
		end
	endtask : send_byte

	// err flips checksum bits to spoil the frame on purpose
	task automatic send_frame(input logic [7:0] d[$], input logic [7:0] err);
		logic [7:0] s;
		s = 8'h00;
		foreach (d[i])
		begin
			send_byte(d[i]);
			s = fold(s, d[i]);
		end
		send_byte(s ^ err);
	endtask : send_frame

	// lead-in and hold are scaled with the bit time
	task automatic send_cmd(input logic [7:0] d[$], input logic [7:0] err);
		@(posedge clk_i);
		#1;
		cmd_n_o = 1'b0;
		repeat (3 * BIT_CYC) @(posedge clk_i);
		send_frame(d, err);
		repeat (2 * BIT_CYC) @(posedge clk_i);
		#1;
		cmd_n_o = 1'b1;
	endtask : send_cmd

	// returns at mid stop bit; w is 3000 when nothing came, -1 on a bad stop bit
	task automatic recv_byte(output logic [7:0] b, output int w);
		w = 0;
		b = 8'h00;
		// falling edge sampling keeps clear of the edge that launches each bit
		while (dev_line_i !== 1'b0 && w < 3000)
		begin
			@(negedge clk_i);
			w++;
		end
		if (w < 3000)
		begin
			repeat (BIT_CYC / 2) @(negedge clk_i);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT_CYC) @(negedge clk_i);
				b[i] = dev_line_i;
			end
			repeat (BIT_CYC) @(negedge clk_i);
			if (dev_line_i !== 1'b1)
				w = -1;
		end
	endtask : recv_byte
endmodule : spb_host_model

`default_nettype wire

/* File: tb/spb_cmd_seq_tb.sv */
`default_nettype none

module spb_cmd_seq_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import spb_pkg::*;
	localparam int         BIT = 16;
	localparam int         DACK = 100;
	localparam int         GAP = 50;
	localparam logic [7:0] DEV = 8'h3c; // arbitrary address
	logic       clk_i = 1'b0;
	logic       reset_n_i = 1'b0;
	logic       host_line, cmd_n, dev_line, cmd_req, wr_strobe, cmd_abort, exec_start, rd_ready;
	logic [7:0] cmd_code, cmd_aux1, cmd_aux2, wr_byte;
	logic       cmd_resp = 1'b0, cmd_ok = 1'b0, exec_done = 1'b0, exec_ok = 1'b0;
	logic       rd_valid = 1'b0;
	logic [7:0] rd_data = 8'h00;
	logic [8:0] cmd_len = 9'h000;
	spb_dir_e   cmd_dir = SPB_DIR_NONE;
	int         bad_count = 0, n_tests = 0, n_req = 0, n_abort = 0;
	logic [7:0] wq[$];

	always #10 clk_i = ~clk_i;

	spb_cmd_seq #(.BIT_CYC(BIT), .DECIDE_CYC(400), .DACK_MIN_CYC(DACK), .RES_GAP_CYC(GAP),
		.DEVICE_ID(DEV)) spb_cmd_seq_i (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .host_line_i(host_line), .cmd_n_i(cmd_n),
		.dev_line_o(dev_line), .cmd_req_o(cmd_req), .cmd_code_o(cmd_code),
		.cmd_aux1_o(cmd_aux1), .cmd_aux2_o(cmd_aux2), .cmd_resp_i(cmd_resp),
		.cmd_ok_i(cmd_ok), .cmd_dir_i(cmd_dir), .cmd_len_i(cmd_len), .wr_byte_o(wr_byte),
		.wr_strobe_o(wr_strobe), .cmd_abort_o(cmd_abort), .exec_start_o(exec_start),
		.exec_done_i(exec_done), .exec_ok_i(exec_ok), .rd_data_i(rd_data),
		.rd_valid_i(rd_valid), .rd_ready_o(rd_ready));

	spb_host_model #(.BIT_CYC(BIT)) spb_host_model_i (.clk_i(clk_i), .dev_line_i(dev_line),
		.host_line_o(host_line), .cmd_n_o(cmd_n));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask : check

	// pulses sampled mid-cycle, away from the edge that launches them
	always @(negedge clk_i)
	begin
		if (wr_strobe === 1'b1)
			wq.push_back(wr_byte);
		n_req += int'(cmd_req === 1'b1);
		n_abort += int'(cmd_abort === 1'b1);
		if (cmd_n === 1'b0)
			check(dev_line, 1'b1);
	end

	task automatic await(ref logic s);
		int k;
		k = 0;
		while (s !== 1'b1 && k < 3000)
		begin
			@(negedge clk_i);
			k++;
		end
		check(32'(k < 3000), 1);
	endtask : await

	task automatic rx(input logic [7:0] exp, output int w);
		logic [7:0] b;
		spb_host_model_i.recv_byte(b, w);
		check(b, exp);
	endtask : rx

	task automatic silent(input int n0);
		logic [7:0] b;
		int         w;
		spb_host_model_i.recv_byte(b, w);
		check(w, 3000);
		check(n_req, n0);
	endtask : silent

	task automatic cmd(input logic [7:0] c, input logic ok, input spb_dir_e dir, input int len);
		wq.delete();
		spb_host_model_i.send_cmd('{DEV, c, 8'h12, 8'hfe}, 8'h00);
		await(cmd_req);
		check(cmd_code, c);
		check({cmd_aux1, cmd_aux2}, 16'h12fe);
		@(posedge clk_i);
		#1;
		cmd_resp = 1'b1;
		cmd_ok = ok;
		cmd_dir = dir;
		cmd_len = 9'(len);
		@(posedge clk_i);
		#1;
		cmd_resp = 1'b0;
	endtask : cmd

	task automatic run_exec(input logic ok, input int nw);
		await(exec_start);
		check(wq.size(), nw);
		@(posedge clk_i);
		#1;
		exec_done = 1'b1;
		exec_ok = ok;
		@(posedge clk_i);
		#1;
		exec_done = 1'b0;
	endtask : run_exec

	task automatic t_plain;
		int w;
		cmd(8'h10, 1'b1, SPB_DIR_NONE, 0);
		fork
			begin
				rx(8'h41, w);
				rx(8'h43, w);
				check(32'(w >= GAP + BIT / 2 - 2), 1);
			end
			run_exec(1'b1, 0);
		join
		$display("plain command done");
	endtask : t_plain

	task automatic t_foreign;
		spb_host_model_i.send_cmd('{DEV ^ 8'h01, 8'h10, 8'h00, 8'h00}, 8'h00);
		silent(n_req);
		spb_host_model_i.send_cmd('{DEV, 8'h10, 8'h00, 8'h00}, 8'h20);
		silent(n_req);
		$display("foreign and corrupt frames done");
	endtask : t_foreign

	task automatic t_nak;
		int w;
		int nr;
		cmd(8'h20, 1'b0, SPB_DIR_NONE, 0);
		rx(8'h4e, w);
		silent(n_req);
		// no verdict from the user side: the deadline must answer instead
		nr = n_req;
		spb_host_model_i.send_cmd('{DEV, 8'h21, 8'h00, 8'h00}, 8'h00);
		rx(8'h4e, w);
		check(32'(w <= 400 + 2 * BIT), 1);
		check(n_req, nr + 1);
		$display("rejected command done");
	endtask : t_nak

	task automatic t_write(input logic [7:0] err);
		int w;
		int na;
		na = n_abort;
		cmd(8'h30, 1'b1, SPB_DIR_WRITE, 2);
		rx(8'h41, w);
		repeat (3 * BIT) @(posedge clk_i);
		spb_host_model_i.send_frame('{8'ha5, 8'h7e}, err);
		if (err != 8'h00)
		begin
			rx(8'h4e, w);
			check(n_abort, na + 1);
			silent(n_req);
		end
		else
		begin
			rx(8'h41, w);
			check(32'(w >= DACK), 1);
			check({wq[0], wq[1]}, 16'ha57e);
			fork
				rx(8'h43, w);
				run_exec(1'b1, 2);
			join
		end
		$display("write command done");
	endtask : t_write

	task automatic t_read;
		int         w;
		logic [7:0] s;
		logic [7:0] d[$];
		d = '{8'h01, 8'hff, 8'h80, 8'hc3, 8'h7f};
		s = 8'h00;
		cmd(8'h61, 1'b1, SPB_DIR_READ, 5);
		fork
			begin
				rx(8'h41, w);
				rx(8'h45, w);
				foreach (d[i])
				begin
					rx(d[i], w);
					s = spb_host_model_i.fold(s, d[i]);
				end
				rx(s, w);
			end
			begin
				run_exec(1'b0, 0);
				// five words into four places: the last waits for draining
				foreach (d[i])
				begin
					rd_data = d[i];
					rd_valid = 1'b1;
					do @(negedge clk_i); while (rd_ready !== 1'b1);
					@(posedge clk_i);
					#1;
				end
				rd_valid = 1'b0;
			end
		join
		$display("read command done");
	endtask : t_read

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	// main sequence after a three-cycle reset
	initial
	begin
		repeat (3) @(posedge clk_i);
		#1;
		reset_n_i = 1'b1;
		repeat (4) @(posedge clk_i);
		t_plain;
		t_foreign;
		t_nak;
		t_write(8'h00);
		t_write(8'h01);
		t_read;
		finish_test;
	end

	// run needs under 40000 cycles; this cuts a hang short
	initial
	begin
		repeat (80000) @(posedge clk_i);
		bad_count++;
		finish_test;
	end
endmodule : spb_cmd_seq_tb

`default_nettype wire
